// File: rtl/prescaled_downcount_pwm_timers.v
`timescale 1ns/100ps
`include "pwm_timer_defines.vh"


module prescaled_downcount_pwm_timers #(
  parameter ADDR_WIDTH = 8,
  parameter NUM_CH = 3
) (
  input wire clock,
  input wire rst_b,
  input wire awvalid,
  output wire awready,
  input wire [ADDR_WIDTH-1:0] awaddr,
  input wire wvalid,
  output wire wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  output reg bvalid,
  input wire bready,
  output reg [1:0] bresp,
  input wire arvalid,
  output wire arready,
  input wire [ADDR_WIDTH-1:0] araddr,
  output reg rvalid,
  input wire rready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  input wire instr_tick,
  input wire ext_count_clock_pin,
  output wire pwm3_out,
  output wire pwm3_oe_n,
  output wire pwm4_out,
  output wire pwm4_oe_n
);

  // ----------------------------------------
  // decode functions
  // ----------------------------------------
  function [5:0] reg_index;
    input [ADDR_WIDTH-1:0] addr;
    begin
      reg_index = addr[7:2];
    end
  endfunction

  function is_mapped;
    input [5:0] idx;
    begin
      is_mapped = ((idx >= `IDX_CH3_COUNT) && (idx <= `IDX_CH5_CLOCK)) ||
        (idx == `IDX_CH5_HIGH) || (idx == `IDX_CH34_HIGH);
    end
  endfunction

  function is_read_only;
    input [5:0] idx;
    begin
      is_read_only = (idx == `IDX_CH3_PSCOUNT) || (idx == `IDX_CH4_PSCOUNT);
    end
  endfunction

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  reg [7:0] mode_ctrl [0:NUM_CH-1];
  reg [7:0] clock_ctrl [0:NUM_CH-1];
  reg [7:0] reload_low [0:NUM_CH-1];
  reg [7:0] ch3_duty_low;
  reg [7:0] ch4_duty_low;
  reg [7:0] ch34_shared_high_bits;
  reg [7:0] ch5_high_bits;
  reg ext_prev;

  // ----------------------------------------
  // write channel state
  // ----------------------------------------
  reg aw_held;
  reg w_held;
  reg [ADDR_WIDTH-1:0] aw_addr_hold;
  reg [31:0] w_data_hold;
  reg [3:0] w_strb_hold;

  wire write_fire;
  wire [5:0] write_idx;
  wire write_ok;
  wire write_byte;
  wire [5:0] read_idx;
  integer i;

  // either order is fine; address and data wait in holding registers
  assign awready = ~aw_held & ~bvalid;
  assign wready = ~w_held & ~bvalid;
  assign write_fire = aw_held & w_held & ~bvalid;
  assign write_idx = reg_index(aw_addr_hold);
  assign write_ok = is_mapped(write_idx) & ~is_read_only(write_idx);
  assign write_byte = write_fire & write_ok & w_strb_hold[0];
  assign arready = ~rvalid;
  assign read_idx = reg_index(araddr);

  always @(posedge clock) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_hold <= {ADDR_WIDTH{1'b0}};
      w_data_hold <= 32'h00000000;
      w_strb_hold <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr_hold <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data_hold <= wdata;
        w_strb_hold <= wstrb;
      end
      if (write_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= write_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  // a ratio change with the prescaler running is taken as written;
  // software keeps the prescaler disabled first to avoid a stray tick
  always @(posedge clock) begin
    if (!rst_b) begin
      for (i = 0; i < NUM_CH; i = i + 1) begin
        mode_ctrl[i] <= `MODE_RESET;
        clock_ctrl[i] <= `CLK_RESET;
        reload_low[i] <= 8'h00;
      end
      ch3_duty_low <= 8'h00;
      ch4_duty_low <= 8'h00;
      ch34_shared_high_bits <= 8'h00;
      ch5_high_bits <= 8'h00;
    end else if (write_byte) begin
      case (write_idx)
        `IDX_CH3_COUNT: begin
          reload_low[0] <= w_data_hold[7:0];
        end
        `IDX_CH3_MODE: begin
          mode_ctrl[0] <= w_data_hold[7:0] & `MODE_MASK;
        end
        `IDX_CH3_CLOCK: begin
          clock_ctrl[0] <= w_data_hold[7:0] & `CLK_MASK;
        end
        `IDX_CH3_DUTY: begin
          ch3_duty_low <= w_data_hold[7:0];
        end
        `IDX_CH4_COUNT: begin
          reload_low[1] <= w_data_hold[7:0];
        end
        `IDX_CH4_MODE: begin
          mode_ctrl[1] <= w_data_hold[7:0] & `MODE_MASK;
        end
        `IDX_CH4_CLOCK: begin
          clock_ctrl[1] <= w_data_hold[7:0] & `CLK_MASK;
        end
        `IDX_CH4_DUTY: begin
          ch4_duty_low <= w_data_hold[7:0];
        end
        `IDX_CH5_COUNT: begin
          reload_low[2] <= w_data_hold[7:0];
        end
        `IDX_CH5_MODE: begin
          mode_ctrl[2] <= w_data_hold[7:0] & `MODE_MASK;
        end
        `IDX_CH5_CLOCK: begin
          clock_ctrl[2] <= w_data_hold[7:0] & `CLK_MASK;
        end
        `IDX_CH5_HIGH: begin
          ch5_high_bits <= w_data_hold[7:0];
        end
        `IDX_CH34_HIGH: begin
          ch34_shared_high_bits <= w_data_hold[7:0];
        end
        default: begin
          ch5_high_bits <= ch5_high_bits;
        end
      endcase
    end
  end

  // ----------------------------------------
  // external pin edges
  // ----------------------------------------
  // the pin is taken as synchronous, so one stage serves for edge detection
  wire ext_rise;
  wire ext_fall;

  always @(posedge clock) begin
    if (!rst_b) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_count_clock_pin;
    end
  end

  assign ext_rise = ext_count_clock_pin & ~ext_prev;
  assign ext_fall = ~ext_count_clock_pin & ext_prev;

  // ----------------------------------------
  // per-channel values
  // ----------------------------------------
  wire [1:0] period_high [0:NUM_CH-1];
  wire [9:0] duty_full [0:NUM_CH-1];
  wire [9:0] count_live [0:NUM_CH-1];
  wire [7:0] ps_live [0:NUM_CH-1];
  wire pwm_level [0:NUM_CH-1];
  wire pwm_oe_level_n [0:NUM_CH-1];

  assign period_high[0] = ch34_shared_high_bits[`HI_CH3_PER_LSB+1:`HI_CH3_PER_LSB];
  assign period_high[1] = ch34_shared_high_bits[`HI_CH4_PER_LSB+1:`HI_CH4_PER_LSB];
  assign period_high[2] = ch5_high_bits[`HI_CH5_PER_LSB+1:`HI_CH5_PER_LSB];
  assign duty_full[0] =
    {ch34_shared_high_bits[`HI_CH3_DUTY_LSB+1:`HI_CH3_DUTY_LSB], ch3_duty_low};
  assign duty_full[1] =
    {ch34_shared_high_bits[`HI_CH4_DUTY_LSB+1:`HI_CH4_DUTY_LSB], ch4_duty_low};
  // the fifth timer's waveform lies outside this block; its duty stays zero
  assign duty_full[2] = 10'h000;

  // ----------------------------------------
  // channels
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1) begin : chan
      wire load_hit;
      assign load_hit = write_byte &&
        (write_idx == ((g == 0) ? `IDX_CH3_COUNT : (g == 1) ? `IDX_CH4_COUNT : `IDX_CH5_COUNT));
      timer_channel unit (
        .clock(clock),
        .rst_b(rst_b),
        .instr_tick(instr_tick),
        .ext_rise(ext_rise),
        .ext_fall(ext_fall),
        .run_enable(mode_ctrl[g][`MODE_RUN]),
        .reload_sel(mode_ctrl[g][`MODE_RELOAD]),
        .single_shot(mode_ctrl[g][`MODE_SINGLE]),
        .clk_src_sel(clock_ctrl[g][`CLK_SRC]),
        .ext_edge_sel(clock_ctrl[g][`CLK_EDGE]),
        .prescale_disable_n(clock_ctrl[g][`CLK_PS_DIS_N]),
        .prescale_ratio_sel(clock_ctrl[g][`CLK_SEL_LSB+2:`CLK_SEL_LSB]),
        .load_strobe(load_hit),
        .load_value({period_high[g], w_data_hold[7:0]}),
        .reload_value({period_high[g], reload_low[g]}),
        .duty(duty_full[g]),
        .out_polarity(mode_ctrl[g][`MODE_POLARITY] & (g != 2)),
        .out_enable(mode_ctrl[g][`MODE_OUT_EN] & (g != 2)),
        .count(count_live[g]),
        .prescale_count(ps_live[g]),
        .pwm_out(pwm_level[g]),
        .pwm_oe_n(pwm_oe_level_n[g])
      );
    end
  endgenerate

  assign pwm3_out = pwm_level[0];
  assign pwm3_oe_n = pwm_oe_level_n[0];
  assign pwm4_out = pwm_level[1];
  assign pwm4_oe_n = pwm_oe_level_n[1];

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  reg [7:0] read_byte;

  always @* begin
    read_byte = 8'h00;
    case (read_idx)
      `IDX_CH3_COUNT: begin
        read_byte = count_live[0][7:0];
      end
      `IDX_CH3_MODE: begin
        read_byte = mode_ctrl[0];
      end
      `IDX_CH3_CLOCK: begin
        read_byte = clock_ctrl[0];
      end
      `IDX_CH3_PSCOUNT: begin
        read_byte = ps_live[0];
      end
      `IDX_CH4_COUNT: begin
        read_byte = count_live[1][7:0];
      end
      `IDX_CH4_MODE: begin
        read_byte = mode_ctrl[1];
      end
      `IDX_CH4_CLOCK: begin
        read_byte = clock_ctrl[1];
      end
      `IDX_CH4_PSCOUNT: begin
        read_byte = ps_live[1];
      end
      `IDX_CH5_COUNT: begin
        read_byte = count_live[2][7:0];
      end
      `IDX_CH5_MODE: begin
        read_byte = mode_ctrl[2];
      end
      `IDX_CH5_CLOCK: begin
        read_byte = clock_ctrl[2];
      end
      `IDX_CH5_HIGH: begin
        read_byte = ch5_high_bits;
      end
      `IDX_CH34_HIGH: begin
        read_byte = ch34_shared_high_bits;
      end
      default: begin
        // duty registers are write-only and read as zero here
        read_byte = 8'h00;
      end
    endcase
  end

  always @(posedge clock) begin
    if (!rst_b) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= {24'h000000, read_byte};
      rresp <= is_mapped(read_idx) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule

// File: rtl/pwm_timer_defines.vh
`ifndef PWM_TIMER_DEFINES_VH
`define PWM_TIMER_DEFINES_VH

// ----------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------
`define IDX_CH3_COUNT 6'h10
`define IDX_CH3_MODE 6'h11
`define IDX_CH3_CLOCK 6'h12
`define IDX_CH3_DUTY 6'h13
`define IDX_CH3_PSCOUNT 6'h14
`define IDX_CH4_COUNT 6'h15
`define IDX_CH4_MODE 6'h16
`define IDX_CH4_CLOCK 6'h17
`define IDX_CH4_DUTY 6'h18
`define IDX_CH4_PSCOUNT 6'h19
`define IDX_CH5_COUNT 6'h1a
`define IDX_CH5_MODE 6'h1b
`define IDX_CH5_CLOCK 6'h1c
`define IDX_CH5_HIGH 6'h1f
`define IDX_CH34_HIGH 6'h21

// ----------------------------------------
// mode and output control fields
// ----------------------------------------
`define MODE_RUN 0
`define MODE_RELOAD 1
`define MODE_SINGLE 2
`define MODE_POLARITY 6
`define MODE_OUT_EN 7
`define MODE_MASK 8'hc7
`define MODE_RESET 8'h00

// ----------------------------------------
// clock and prescaler control fields
// ----------------------------------------
`define CLK_SEL_LSB 0
`define CLK_PS_DIS_N 3
`define CLK_EDGE 4
`define CLK_SRC 5
`define CLK_MASK 8'h3f
`define CLK_RESET 8'h3f

// ----------------------------------------
// high bit positions and reset values
// ----------------------------------------
`define HI_CH3_DUTY_LSB 0
`define HI_CH4_DUTY_LSB 2
`define HI_CH3_PER_LSB 4
`define HI_CH4_PER_LSB 6
`define HI_CH5_PER_LSB 4
`define COUNT_RESET 10'h3ff
`define COUNT_FREE_LOAD 10'h3ff
`define PSCOUNT_RESET 8'hff
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// File: rtl/timer_channel.v
`timescale 1ns/100ps
`include "pwm_timer_defines.vh"

module timer_channel (
  input wire clock,
  input wire rst_b,
  input wire instr_tick,
  input wire ext_rise,
  input wire ext_fall,
  input wire run_enable,
  input wire reload_sel,
  input wire single_shot,
  input wire clk_src_sel,
  input wire ext_edge_sel,
  input wire prescale_disable_n,
  input wire [2:0] prescale_ratio_sel,
  input wire load_strobe,
  input wire [9:0] load_value,
  input wire [9:0] reload_value,
  input wire [9:0] duty,
  input wire out_polarity,
  input wire out_enable,
  output reg [9:0] count,
  output reg [7:0] prescale_count,
  output reg pwm_out,
  output wire pwm_oe_n
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function [7:0] ratio_mask;
    input [2:0] sel;
    begin
      ratio_mask = (8'h02 << sel) - 8'h01;
    end
  endfunction

  // ----------------------------------------
  // source event and prescaler
  // ----------------------------------------
  wire src_event;
  wire [7:0] next_prescale_count;
  wire prescale_tick;
  wire count_tick;

  assign src_event = clk_src_sel ? (ext_edge_sel ? ext_fall : ext_rise) : instr_tick;
  assign next_prescale_count = prescale_count + 8'h01;
  // tick when the selected low bits wrap, so the ratio is a power of two
  assign prescale_tick = src_event &
    ((next_prescale_count & ratio_mask(prescale_ratio_sel)) == 8'h00);
  assign count_tick = run_enable & (prescale_disable_n ? src_event : prescale_tick);

  always @(posedge clock) begin
    if (!rst_b) begin
      prescale_count <= `PSCOUNT_RESET;
    end else if (prescale_disable_n) begin
      prescale_count <= `PSCOUNT_RESET;
    end else if (run_enable && src_event) begin
      prescale_count <= next_prescale_count;
    end
  end

  // ----------------------------------------
  // down-counter
  // ----------------------------------------
  always @(posedge clock) begin
    if (!rst_b) begin
      count <= `COUNT_RESET;
    end else if (load_strobe) begin
      count <= load_value;
    end else if (count_tick) begin
      if (count != 10'h000) begin
        count <= count - 10'h001;
      end else if (single_shot) begin
        count <= 10'h000;
      end else if (reload_sel) begin
        count <= reload_value;
      end else begin
        count <= `COUNT_FREE_LOAD;
      end
    end
  end

  // ----------------------------------------
  // pwm output
  // ----------------------------------------
  always @(posedge clock) begin
    if (!rst_b) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= (count <= duty) ^ out_polarity;
    end
  end

  assign pwm_oe_n = ~out_enable;

endmodule

// File: testbench/pwm_timers_sva.sv
`timescale 1ns/100ps
`include "pwm_timer_defines.vh"

module pwm_timers_sva #(
  parameter ADDR_WIDTH = 8,
  parameter NUM_CH = 3
) (
  input wire clock,
  input wire rst_b,
  input wire awvalid,
  input wire awready,
  input wire [ADDR_WIDTH-1:0] awaddr,
  input wire wvalid,
  input wire wready,
  input wire bvalid,
  input wire bready,
  input wire [1:0] bresp,
  input wire arvalid,
  input wire arready,
  input wire [ADDR_WIDTH-1:0] araddr,
  input wire rvalid,
  input wire rready,
  input wire [31:0] rdata,
  input wire pwm3_oe_n,
  input wire pwm4_oe_n
);
  // ----------------------------------------
  // bus and output checks
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  // the write and bvalid both land one edge after both halves are held; bvalid is sampled on the edge after
  a_write_answered: assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid)
    else $error("write not answered within two cycles");
  a_read_answered: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered next cycle");
  a_bvalid_clears: assert property (bvalid && bready |=> !bvalid)
    else $error("write response not released");
  a_rvalid_clears: assert property (rvalid && rready |=> !rvalid)
    else $error("read response not released");
  a_read_low_byte: assert property (rvalid |-> rdata[31:8] == 24'h000000)
    else $error("read data above bit 7 not zero");
  // the prescale count is live, so a write there must be refused, not stored
  a_pscount_ro: assert property (awvalid && awready && wvalid && wready
    && (awaddr[7:2] == `IDX_CH3_PSCOUNT || awaddr[7:2] == `IDX_CH4_PSCOUNT)
    |=> ##1 bvalid && bresp == `RESP_SLVERR) else $error("prescale count write accepted");
  a_duty_hidden: assert property (arvalid && arready && araddr[7:2] == `IDX_CH4_DUTY
    |=> rdata == 32'h00000000) else $error("duty read not zero");
  a_oe_after_reset: assert property ($rose(rst_b) |-> pwm3_oe_n && pwm4_oe_n)
    else $error("pwm pin driven out of reset");
  a_busy_refuses: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
endmodule

bind prescaled_downcount_pwm_timers pwm_timers_sva #(
  .ADDR_WIDTH(ADDR_WIDTH),
  .NUM_CH(NUM_CH)
) i_pwm_timers_sva (.clock, .rst_b, .awvalid, .awready, .awaddr, .wvalid, .wready,
  .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
  .pwm3_oe_n, .pwm4_oe_n);

// File: testbench/tb_top.sv
`timescale 1ns/100ps
`include "pwm_timer_defines.vh"

module tb_top;
  reg clock, rst_b, awvalid, wvalid, bready, arvalid, rready, instr_tick, ext_count_clock_pin;
  reg [7:0] awaddr, araddr;
  reg [31:0] wdata, n;
  reg [3:0] wstrb;
  wire awready, wready, bvalid, arready, rvalid, pwm3_out, pwm3_oe_n, pwm4_out, pwm4_oe_n;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer mismatches, samples_checked, cycles, i;

  prescaled_downcount_pwm_timers i_prescaled_downcount_pwm_timers (.clock, .rst_b,
    .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .instr_tick,
    .ext_count_clock_pin, .pwm3_out, .pwm3_oe_n, .pwm4_out, .pwm4_oe_n);

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task check(input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task wr(input [5:0] idx, input [7:0] d, input [1:0] er);
    reg a, w;
    begin
      a = 0;
      w = 0;
      awvalid <= 1;
      wvalid <= 1;
      awaddr <= {idx, 2'b00};
      wdata <= {24'h000000, d};
      bready <= 1;
      while (!(a && w)) begin
        @(posedge clock);
        if (!a && awready) begin
          a = 1;
          awvalid <= 0;
        end
        if (!w && wready) begin
          w = 1;
          wvalid <= 0;
        end
      end
      do @(posedge clock); while (!bvalid);
      check(bresp, er);
    end
  endtask

  // data is only judged on an accepted read
  task rd(input [5:0] idx, input [7:0] exp, input [1:0] er);
    begin
      arvalid <= 1;
      araddr <= {idx, 2'b00};
      rready <= 1;
      do @(posedge clock); while (!arready);
      arvalid <= 0;
      do @(posedge clock); while (!rvalid);
      check(rresp, er);
      if (er == `RESP_OKAY)
        check(rdata, {24'h000000, exp});
    end
  endtask

  task tick(input integer k);
    begin
      repeat (k) begin
        instr_tick <= 1;
        @(posedge clock);
        instr_tick <= 0;
        @(posedge clock);
      end
    end
  endtask

  // five toggles: three edges of the starting sense, two of the other
  task walk;
    begin
      repeat (5) begin
        ext_count_clock_pin <= !ext_count_clock_pin;
        repeat (3) @(posedge clock);
      end
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    begin
      rd(`IDX_CH4_MODE, 8'h00, `RESP_OKAY);
      rd(`IDX_CH3_CLOCK, 8'h3f, `RESP_OKAY);
      rd(`IDX_CH4_CLOCK, 8'h3f, `RESP_OKAY);
      rd(`IDX_CH3_PSCOUNT, 8'hff, `RESP_OKAY);
      rd(`IDX_CH4_PSCOUNT, 8'hff, `RESP_OKAY);
      rd(`IDX_CH4_COUNT, 8'hff, `RESP_OKAY);
      rd(`IDX_CH5_COUNT, 8'hff, `RESP_OKAY);
      check(pwm4_oe_n, 1'b1);
    end
  endtask

  task t_bus_errors;
    begin
      wr(6'h3f, 8'h00, `RESP_SLVERR);
      rd(6'h3f, 8'h00, `RESP_SLVERR);
      wr(`IDX_CH3_PSCOUNT, 8'h12, `RESP_SLVERR);
      wr(`IDX_CH4_PSCOUNT, 8'h34, `RESP_SLVERR);
      wr(`IDX_CH4_DUTY, 8'h5a, `RESP_OKAY);
      rd(`IDX_CH4_DUTY, 8'h00, `RESP_OKAY);
      rd(`IDX_CH4_PSCOUNT, 8'hff, `RESP_OKAY);
    end
  endtask

  task t_ch4_pwm;
    begin
      wr(`IDX_CH34_HIGH, 8'h40, `RESP_OKAY);
      wr(`IDX_CH4_DUTY, 8'hff, `RESP_OKAY);
      wr(`IDX_CH4_CLOCK, 8'h08, `RESP_OKAY);
      wr(`IDX_CH4_COUNT, 8'h02, `RESP_OKAY);
      wr(`IDX_CH4_MODE, 8'h80, `RESP_OKAY);
      tick(2);
      rd(`IDX_CH4_COUNT, 8'h02, `RESP_OKAY);
      check(pwm4_oe_n, 1'b0);
      check(pwm4_out, 1'b0);
      wr(`IDX_CH4_MODE, 8'hc0, `RESP_OKAY);
      repeat (2) @(posedge clock);
      check(pwm4_out, 1'b1);
      wr(`IDX_CH4_MODE, 8'h83, `RESP_OKAY);
      tick(3);
      rd(`IDX_CH4_COUNT, 8'hff, `RESP_OKAY);
      check(pwm4_out, 1'b1);
    end
  endtask

  task t_ch4_modes;
    begin
      tick(256);
      rd(`IDX_CH4_COUNT, 8'h02, `RESP_OKAY);
      check(pwm4_out, 1'b0);
      wr(`IDX_CH34_HIGH, 8'h44, `RESP_OKAY);
      repeat (2) @(posedge clock);
      check(pwm4_out, 1'b1);
      wr(`IDX_CH4_MODE, 8'h81, `RESP_OKAY);
      tick(259);
      rd(`IDX_CH4_COUNT, 8'hff, `RESP_OKAY);
      tick(1);
      rd(`IDX_CH4_COUNT, 8'hfe, `RESP_OKAY);
      wr(`IDX_CH34_HIGH, 8'h00, `RESP_OKAY);
      wr(`IDX_CH4_COUNT, 8'h03, `RESP_OKAY);
      wr(`IDX_CH4_MODE, 8'h87, `RESP_OKAY);
      tick(5);
      rd(`IDX_CH4_COUNT, 8'h00, `RESP_OKAY);
    end
  endtask

  // ratio is always chosen with the prescaler bypassed, then enabled
  task t_prescale;
    begin
      wr(`IDX_CH4_MODE, 8'h81, `RESP_OKAY);
      for (i = 0; i < 8; i = i + 1) begin
        wr(`IDX_CH4_CLOCK, 8'h08 | i[7:0], `RESP_OKAY);
        wr(`IDX_CH4_COUNT, 8'h50, `RESP_OKAY);
        wr(`IDX_CH4_CLOCK, i[7:0], `RESP_OKAY);
        n = (32'h4 << i) - 32'h1;
        tick(4 << i);
        rd(`IDX_CH4_COUNT, 8'h4e, `RESP_OKAY);
        rd(`IDX_CH4_PSCOUNT, n[7:0], `RESP_OKAY);
        wr(`IDX_CH4_CLOCK, 8'h08 | i[7:0], `RESP_OKAY);
      end
    end
  endtask

  task t_ch3_ext;
    begin
      wr(`IDX_CH34_HIGH, 8'h10, `RESP_OKAY);
      wr(`IDX_CH3_DUTY, 8'hff, `RESP_OKAY);
      wr(`IDX_CH3_CLOCK, 8'h28, `RESP_OKAY);
      wr(`IDX_CH3_COUNT, 8'h40, `RESP_OKAY);
      wr(`IDX_CH3_MODE, 8'h81, `RESP_OKAY);
      walk;
      tick(4);
      rd(`IDX_CH3_COUNT, 8'h3d, `RESP_OKAY);
      check(pwm3_oe_n, 1'b0);
      check(pwm3_out, 1'b0);
      wr(`IDX_CH34_HIGH, 8'h11, `RESP_OKAY);
      repeat (2) @(posedge clock);
      check(pwm3_out, 1'b1);
      wr(`IDX_CH3_CLOCK, 8'h38, `RESP_OKAY);
      wr(`IDX_CH3_COUNT, 8'h40, `RESP_OKAY);
      walk;
      rd(`IDX_CH3_COUNT, 8'h3d, `RESP_OKAY);
      wr(`IDX_CH5_HIGH, 8'h10, `RESP_OKAY);
      wr(`IDX_CH5_COUNT, 8'h77, `RESP_OKAY);
      rd(`IDX_CH5_COUNT, 8'h77, `RESP_OKAY);
      // one-shot with reload set: two falling edges from a count of one must stop at zero
      wr(`IDX_CH34_HIGH, 8'h00, `RESP_OKAY);
      wr(`IDX_CH3_COUNT, 8'h01, `RESP_OKAY);
      wr(`IDX_CH3_MODE, 8'h07, `RESP_OKAY);
      walk;
      rd(`IDX_CH3_COUNT, 8'h00, `RESP_OKAY);
    end
  endtask

  task wrap_up;
    begin
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // ----------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    clock = 0;
    forever #2.5 clock = !clock;
  end

  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      wrap_up;
    end
  end

  initial begin
    mismatches = 0;
    samples_checked = 0;
    cycles = 0;
    rst_b = 0;
    {awvalid, wvalid, bready, arvalid, rready, instr_tick, ext_count_clock_pin} = 7'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'h1;
    repeat (10) @(posedge clock);
    rst_b <= 1;
    @(posedge clock);
    t_reset;
    t_bus_errors;
    t_ch4_pwm;
    t_ch4_modes;
    t_prescale;
    t_ch3_ext;
    wrap_up;
  end
endmodule
